// *** verilog/micro_pkg.sv ***
// Constants, field layout and carrier types for the microprogram sequencer.
// Assumes one processor clock; all consumers import the whole package.
package micro_pkg;
	// Control store geometry
	localparam int CS_DEPTH = 256;
	localparam int CS_WIDTH = 40;
	typedef logic [7:0] step_addr_t;
	typedef logic [CS_WIDTH-1:0] cs_word_t;

	// Field positions inside a control store word
	localparam int NEXT_LSB = 0;
	localparam int TEST_LSB = 8;
	localparam int SCR_A2_BIT = 12;
	localparam int SCR_FUNC_BIT = 13;
	localparam int B_UPPER_BIT = 14;
	localparam int CARRY_BIT = 15;
	localparam int B_LOWER_BIT = 16;
	localparam int MUX_SEL1_BIT = 17;
	localparam int SCR_A0_BIT = 18;
	localparam int MUX_SEL0_BIT = 19;
	localparam int AUX_BIT = 20;
	localparam int SCR_A3_BIT = 21;
	localparam int SCR_A1_BIT = 22;
	localparam int B_REG_LSB = 23;
	localparam int A_LEG_LSB = 25;
	localparam int BUS_KIND_LSB = 27;
	localparam int BYTE_OK_BIT = 29;
	localparam int HOLD_BIT = 30;
	localparam int ADDR_REG_BIT = 31;
	localparam int STATUS_LD_BIT = 32;
	localparam int ALU_LSB = 33;

	// Branch-test field codes: no-test, ten branches, five strobes
	typedef enum logic [3:0] {
		TEST_NONE = 4'h0, TEST_JUMP_CALL = 4'h1, TEST_OPCODE = 4'h2,
		TEST_OCTET = 4'h3, TEST_DEST_MODE = 4'h4, TEST_TRANSFER = 4'h5,
		TEST_INTR = 4'h6, TEST_UNARY = 4'h7, TEST_CONSOLE = 4'h8,
		TEST_NONMODIFY = 4'h9, TEST_SERVICE = 4'ha, STB_LITERAL = 4'hb,
		STB_BUS_RESET = 4'hc, STB_SLAVE_SYNC = 4'hd, STB_STACK_CHECK = 4'he,
		STB_IR_CAPTURE = 4'hf
	} test_code_t;

	// B register actions
	localparam logic [1:0] B_HOLD = 2'h0;
	localparam logic [1:0] B_LOAD = 2'h1;
	localparam logic [1:0] B_SHIFT_RIGHT = 2'h2;
	localparam logic [1:0] B_SHIFT_LEFT = 2'h3;
	// A-leg sources
	localparam logic [1:0] A_LEG_SCRATCH = 2'h0;
	localparam logic [1:0] A_LEG_IDLE = 2'h1;
	localparam logic [1:0] A_LEG_SCRATCH_LOW_HALF = 2'h2;
	localparam logic [1:0] A_LEG_STATUS = 2'h3;
	// Bus cycle kinds
	localparam logic [1:0] BUS_NONE = 2'h0;
	localparam logic [1:0] BUS_DATI = 2'h1;
	localparam logic [1:0] BUS_DATO = 2'h2;
	localparam logic [1:0] BUS_DATIP = 2'h3;
	// Scratch address multiplexer sources
	localparam logic [1:0] MUX_FROM_WORD = 2'h0;
	localparam logic [1:0] MUX_FROM_SRC = 2'h1;
	localparam logic [1:0] MUX_FROM_DEST = 2'h2;
	localparam logic [1:0] MUX_FROM_ADDR_REG = 2'h3;
	// ALU functions; only the OR code is fixed, the rest are plain choices
	localparam logic [4:0] ALU_PASS_A_LOGIC = 5'h00;
	localparam logic [4:0] ALU_PASS_A_ARITH = 5'h01;
	localparam logic [4:0] ALU_AND_OF_LEGS = 5'h02;
	localparam logic [4:0] ALU_A_AND_NOT_B = 5'h03;
	localparam logic [4:0] ALU_ZERO = 5'h04;
	localparam logic [4:0] ALU_A_OR_B = 5'h09;

	// Sequencer start point and B-leg constant one
	localparam step_addr_t START_STEP = 8'h00;
	localparam logic [15:0] B_CONST_ONE = 16'h0001;

	// Register map (byte addresses) and bus answers
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CS_ADDR = 8'h08;
	localparam logic [7:0] REG_CS_LO = 8'h0c;
	localparam logic [7:0] REG_CS_HI = 8'h10;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_STEP_BIT = 1;
	localparam int CTRL_RESTART_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Conditions from the data path that feed the branch tests
	typedef struct packed {
		logic [15:0] ir;
		logic [2:0] addr_low;
		logic [7:0] decode_target;
		logic int_pending;
		logic [2:0] console_key;
		logic [3:0] service_code;
	} branch_cond_t;

	// Control fields delivered to the data path for one microstep
	typedef struct packed {
		logic step_valid;
		logic [1:0] b_reg_control;
		logic [1:0] a_leg_select;
		logic [4:0] alu_fn;
		logic alu_aux;
		logic alu_carry_input;
		logic [1:0] b_leg_select;
		logic [3:0] scratch_addr;
		logic scratch_store;
		logic addr_reg_load;
		logic status_word_ctl;
		logic [1:0] bus_cycle_kind;
		logic byte_access_allow;
		logic clock_hold_on_bus;
		logic literal_rom_select;
		logic bus_reset_trigger;
		logic slave_sync_assert;
		logic stack_limit_check_en;
		logic instr_reg_capture;
	} ctrl_t;
endpackage : micro_pkg

// *** verilog/micro_sequencer.sv ***
// Microprogram sequencer: writable control store, step counter, branch
// tests, field decode and an AXI4-Lite register slave.
// Assumes data path conditions and bus handshakes arrive on clk.
`timescale 1ns/10ps

module micro_sequencer
	import micro_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic bus_init,
	input wire logic bus_done,
	input wire branch_cond_t cond,
	input wire logic [15:0] b_reg_value,
	output ctrl_t ctrl,
	output logic [15:0] b_leg_data,
	output step_addr_t micro_step_counter,
	output logic clock_hold_active,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);

	typedef struct packed {
		step_addr_t counter;
		logic waiting;
		logic run;
		logic step_pend;
		ctrl_t ctrl;
		logic [15:0] b_leg_data;
		step_addr_t cs_addr;
		logic [31:0] lo_stage;
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	state_t s;
	state_t next_s;

	// Control store kept outside the state struct; too wide to flatten
	cs_word_t cs_mem [CS_DEPTH];
	logic cs_we;
	step_addr_t cs_waddr;
	cs_word_t cs_wdata;
	cs_word_t word;
	cs_word_t cs_rd;

	// Byte-lane merge for partial AXI writes
	function automatic logic [31:0] merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Address bits that the active branch test forces high
	function automatic step_addr_t branch_mask(input test_code_t t,
			input branch_cond_t c);
		logic byte_op;
		step_addr_t m;
		byte_op = c.ir[15] & (c.ir[14:12] != 3'h6);
		m = 8'h00;
		unique case (t)
			TEST_JUMP_CALL: m[0] = (c.ir[15:9] == 7'h04);
			TEST_OPCODE: m = c.decode_target;
			TEST_OCTET: m[1:0] = {byte_op, byte_op & c.addr_low[0]};
			TEST_DEST_MODE: m[2:0] = c.ir[5:3];
			TEST_TRANSFER: m[1:0] = {c.ir[14:12] == 3'h1, c.ir[15]};
			TEST_INTR: m[0] = c.int_pending;
			TEST_UNARY: m[1:0] = {c.ir[15:6] == 10'h003,
				(c.ir[15:6] == 10'h001) & (c.ir[5:3] == 3'h0)};
			TEST_CONSOLE: m[2:0] = c.console_key;
			TEST_NONMODIFY: m[0] = (c.ir[14:12] == 3'h2)
				| (c.ir[14:12] == 3'h3) | (c.ir[14:6] == 9'h02f);
			TEST_SERVICE: m[3:0] = c.service_code;
			// Strobe codes and no-test leave the address alone
			TEST_NONE, STB_LITERAL, STB_BUS_RESET, STB_SLAVE_SYNC,
			STB_STACK_CHECK, STB_IR_CAPTURE: m = 8'h00;
		endcase
		return m;
	endfunction : branch_mask

	// Split fields of one word into the data path controls
	function automatic ctrl_t decode(input cs_word_t w,
			input branch_cond_t c);
		ctrl_t d;
		test_code_t t;
		logic [1:0] msel;
		t = test_code_t'(w[TEST_LSB +: 4]);
		msel = {w[MUX_SEL0_BIT], w[MUX_SEL1_BIT]};
		d = '0;
		d.step_valid = 1'b1;
		d.b_reg_control = w[B_REG_LSB +: 2];
		d.a_leg_select = w[A_LEG_LSB +: 2];
		d.alu_fn = w[ALU_LSB +: 5];
		d.alu_aux = w[AUX_BIT];
		d.alu_carry_input = w[CARRY_BIT];
		d.b_leg_select = {w[B_UPPER_BIT], w[B_LOWER_BIT]};
		d.scratch_store = w[SCR_FUNC_BIT];
		d.addr_reg_load = w[ADDR_REG_BIT];
		d.status_word_ctl = w[STATUS_LD_BIT];
		d.bus_cycle_kind = w[BUS_KIND_LSB +: 2];
		d.byte_access_allow = w[BYTE_OK_BIT];
		d.clock_hold_on_bus = w[HOLD_BIT];
		// Register numbers R0..octal, so four bits
		unique case (msel)
			MUX_FROM_WORD: d.scratch_addr = {w[SCR_A3_BIT],
				w[SCR_A2_BIT], w[SCR_A1_BIT], w[SCR_A0_BIT]};
			MUX_FROM_SRC: d.scratch_addr = {1'b0, c.ir[8:6]};
			MUX_FROM_DEST: d.scratch_addr = {1'b0, c.ir[2:0]};
			MUX_FROM_ADDR_REG: d.scratch_addr = {1'b0, c.addr_low};
		endcase
		d.literal_rom_select = (t == STB_LITERAL);
		d.bus_reset_trigger = (t == STB_BUS_RESET);
		d.slave_sync_assert = (t == STB_SLAVE_SYNC);
		d.stack_limit_check_en = (t == STB_STACK_CHECK);
		d.instr_reg_capture = (t == STB_IR_CAPTURE);
		return d;
	endfunction : decode

	// B-leg value; the lower select bit wins and gives constant one
	function automatic logic [15:0] b_leg(input logic [1:0] sel,
			input logic [15:0] b);
		logic [15:0] v;
		if (sel[0]) begin
			v = B_CONST_ONE;
		end else if (sel[1]) begin
			v = {{8{b[7]}}, b[7:0]};
		end else begin
			v = b;
		end
		return v;
	endfunction : b_leg

	assign word = cs_mem[s.counter];
	assign cs_rd = cs_mem[s.cs_addr];

	// Next-state logic: sequencer first, then bus writes override
	always_comb begin
		logic fire;
		logic aw_take;
		logic w_take;
		logic ar_take;
		logic [7:0] waddr;
		logic [31:0] wval;
		logic [31:0] old_v;
		next_s = s;
		cs_we = 1'b0;
		cs_waddr = s.cs_addr;
		cs_wdata = '0;
		fire = 1'b0;
		aw_take = 1'b0;
		w_take = 1'b0;
		ar_take = 1'b0;
		waddr = 8'h00;
		wval = 32'h0;
		old_v = 32'h0;

		// Idle cycle: selects stay, every action drops to hold
		next_s.ctrl.step_valid = 1'b0;
		next_s.ctrl.b_reg_control = B_HOLD;
		next_s.ctrl.scratch_store = 1'b0;
		next_s.ctrl.addr_reg_load = 1'b0;
		next_s.ctrl.status_word_ctl = 1'b0;
		next_s.ctrl.bus_cycle_kind = BUS_NONE;
		next_s.ctrl.literal_rom_select = 1'b0;
		next_s.ctrl.bus_reset_trigger = 1'b0;
		next_s.ctrl.slave_sync_assert = 1'b0;
		next_s.ctrl.stack_limit_check_en = 1'b0;
		next_s.ctrl.instr_reg_capture = 1'b0;

		// Held microstep resumes once the bus transfer completes
		if (s.waiting && bus_done) begin
			next_s.waiting = 1'b0;
		end

		// One microstep per enabled cycle
		fire = (s.run | s.step_pend) & ~s.waiting & ~bus_init;
		if (fire) begin
			next_s.ctrl = decode(word, cond);
			next_s.b_leg_data = b_leg({word[B_UPPER_BIT],
				word[B_LOWER_BIT]}, b_reg_value);
			next_s.counter = word[NEXT_LSB +: 8]
				| branch_mask(test_code_t'(word[TEST_LSB +: 4]),
				cond);
			next_s.step_pend = 1'b0;
			next_s.waiting = word[HOLD_BIT];
		end

		// Bus init restarts the program from a known step
		if (bus_init) begin
			next_s.counter = START_STEP;
			next_s.waiting = 1'b0;
		end

		// AXI write channels, either order, one write in flight
		aw_take = s_axi_awvalid & s.awready;
		w_take = s_axi_wvalid & s.wready;
		if (aw_take) begin
			next_s.aw_full = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			next_s.w_full = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (next_s.aw_full && next_s.w_full && !s.bvalid) begin
			waddr = {next_s.aw_addr[7:2], 2'b00};
			next_s.aw_full = 1'b0;
			next_s.w_full = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			unique case (waddr)
				REG_CTRL: old_v = {29'h0, 2'b00, s.run};
				REG_CS_ADDR: old_v = {24'h0, s.cs_addr};
				REG_CS_LO: old_v = s.lo_stage;
				default: old_v = 32'h0;
			endcase
			wval = merge(old_v, next_s.w_data, next_s.w_strb);
			unique case (waddr)
				REG_CTRL: begin
					next_s.run = wval[CTRL_RUN_BIT];
					// A request here is not lost to a step taken now
					if (wval[CTRL_STEP_BIT]) begin
						next_s.step_pend = 1'b1;
					end
					if (wval[CTRL_RESTART_BIT]) begin
						next_s.counter = START_STEP;
						next_s.waiting = 1'b0;
					end
				end
				REG_STATUS: begin
				end
				REG_CS_ADDR: next_s.cs_addr = wval[7:0];
				REG_CS_LO: next_s.lo_stage = wval;
				REG_CS_HI: begin
					// Upper half commits the word, address advances
					cs_we = 1'b1;
					cs_wdata = {wval[7:0], s.lo_stage};
					next_s.cs_addr = s.cs_addr + 8'h01;
				end
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		next_s.awready = ~next_s.aw_full & ~next_s.bvalid;
		next_s.wready = ~next_s.w_full & ~next_s.bvalid;

		// AXI read: answer one cycle after the address is taken
		ar_take = s_axi_arvalid & s.arready;
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (ar_take) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				REG_CTRL: next_s.rdata = {29'h0, 2'b00, s.run};
				REG_STATUS: next_s.rdata = {22'h0, s.run, s.waiting,
					s.counter};
				REG_CS_ADDR: next_s.rdata = {24'h0, s.cs_addr};
				REG_CS_LO: next_s.rdata = cs_rd[31:0];
				REG_CS_HI: next_s.rdata = {24'h0, cs_rd[39:32]};
				default: begin
					next_s.rdata = 32'h0;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end
		next_s.arready = ~next_s.rvalid;
	end

	// State register; clock enable freezes everything
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.counter <= START_STEP;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// Store write port; contents are undefined until software loads them
	always_ff @(posedge clk) begin
		if (ce && cs_we) begin
			cs_mem[cs_waddr] <= cs_wdata;
		end
	end

	// Outputs straight from the state register
	assign ctrl = s.ctrl;
	assign b_leg_data = s.b_leg_data;
	assign micro_step_counter = s.counter;
	assign clock_hold_active = s.waiting;
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;

endmodule : micro_sequencer

// *** tb/micro_chk.sv ***
// Concurrent checks on the sequencer's top-level ports.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/10ps
module micro_chk
	import micro_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bus_init,
	input wire logic bus_done,
	input wire logic [15:0] b_reg_value,
	input wire ctrl_t ctrl,
	input wire logic [15:0] b_leg_data,
	input wire step_addr_t micro_step_counter,
	input wire logic clock_hold_active,
	input wire logic s_axi_bvalid
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Bus wait: entered with the step, left only on completion, bus init or a restart write
	AST_HOLD_STOPS: assert property (
		clock_hold_active |=> !ctrl.step_valid)
		else $error("step issued during bus wait");
	AST_HOLD_RISE: assert property (
		ctrl.step_valid |-> clock_hold_active == ctrl.clock_hold_on_bus)
		else $error("bus wait does not follow hold field");
	AST_HOLD_END: assert property (
		clock_hold_active && bus_done |=> !clock_hold_active)
		else $error("bus wait outlived completion");
	AST_HOLD_KEEP: assert property (
		clock_hold_active && !bus_done && !bus_init
		|=> clock_hold_active)
		else $error("bus wait ended early");
	// Bus init forces the start step
	AST_INIT: assert property (
		bus_init |=> micro_step_counter == START_STEP
		&& !ctrl.step_valid)
		else $error("bus init did not restart");
	// Action fields are quiet between steps; one strobe at most
	AST_IDLE_QUIET: assert property (
		!ctrl.step_valid |-> ctrl.b_reg_control == B_HOLD
		&& !ctrl.scratch_store && ctrl.bus_cycle_kind == BUS_NONE)
		else $error("action without step");
	AST_ONE_STROBE: assert property (
		$onehot0({ctrl.literal_rom_select, ctrl.bus_reset_trigger,
		ctrl.slave_sync_assert, ctrl.stack_limit_check_en,
		ctrl.instr_reg_capture}))
		else $error("several strobes at once");
	// B-leg sources
	AST_SIGN_EXT: assert property (
		ctrl.step_valid && ctrl.b_leg_select == 2'b10 |-> b_leg_data
		== {{8{$past(b_reg_value[7])}}, $past(b_reg_value[7:0])})
		else $error("sign extension wrong");
	AST_CONST_ONE: assert property (
		ctrl.step_valid && ctrl.b_leg_select[0]
		|-> b_leg_data == B_CONST_ONE)
		else $error("constant one wrong");
	// Counter moves only on steps, init or a committed register write
	AST_COUNTER_STILL: assert property (
		!ctrl.step_valid && !$past(bus_init) && !$rose(s_axi_bvalid)
		|-> $stable(micro_step_counter))
		else $error("counter moved without step");

	COV_HOLD: cover property (ctrl.step_valid && clock_hold_active);
	COV_SEX: cover property (ctrl.step_valid && ctrl.b_leg_select == 2'b10);
	COV_INIT: cover property (bus_init ##1 !bus_init);
endmodule : micro_chk

bind micro_sequencer micro_chk u_chk (.clk(clk), .rst_n(rst_n),
	.bus_init(bus_init), .bus_done(bus_done), .b_reg_value(b_reg_value),
	.ctrl(ctrl), .b_leg_data(b_leg_data),
	.micro_step_counter(micro_step_counter),
	.clock_hold_active(clock_hold_active),
	.s_axi_bvalid(s_axi_bvalid));

// *** tb/datapath_model.sv ***
// Data path partner: B register and bus transfer completion.
// Assumes ctrl comes from the sequencer on the same clock.
`timescale 1ns/10ps
module datapath_model
	import micro_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire ctrl_t ctrl,
	output logic [15:0] b_reg_value,
	output logic bus_done
);
	logic [3:0] wait_cnt;

	// B register action and transfer latency, prompt or slow
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			b_reg_value <= 16'h0000;
			wait_cnt <= 4'h0;
			bus_done <= 1'b0;
		end else begin
			bus_done <= (wait_cnt == 4'h1);
			if (wait_cnt != 4'h0)
				wait_cnt <= wait_cnt - 4'h1;
			if (ctrl.step_valid) begin
				case (ctrl.b_reg_control)
				B_LOAD: b_reg_value <= 16'($urandom());
				B_SHIFT_RIGHT: b_reg_value <= b_reg_value >> 1;
				B_SHIFT_LEFT: b_reg_value <= b_reg_value << 1;
				default: ;
				endcase
				// A started cycle ends one to six counts later, never at once
				if (ctrl.bus_cycle_kind != BUS_NONE)
					wait_cnt <= 4'h1 + 4'(slow ? $urandom_range(5) : 0);
			end
		end
	end
endmodule : datapath_model

// *** tb/tb_top.sv ***
// Self-checking bench for the microprogram sequencer.
// Assumes the data path partner model and the bound checker.
`timescale 1ns/10ps
module tb_top
	import micro_pkg::*;
;
	logic clk, rst_n = 1'b0, bus_init = 1'b0, bus_done, slow = 1'b0;
	branch_cond_t cond = '0;
	logic [15:0] b_reg_value, b_leg_data, s_b, s_bp, b_prev;
	ctrl_t ctrl, s_ctrl;
	step_addr_t cnt, s_cnt, ring_ex;
	logic hold, s_hold, got, ring = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	int bad_count = 0, total_checks = 0, steps = 0;

	micro_sequencer dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.bus_init(bus_init), .bus_done(bus_done), .cond(cond),
		.b_reg_value(b_reg_value), .ctrl(ctrl), .b_leg_data(b_leg_data),
		.micro_step_counter(cnt), .clock_hold_active(hold),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp));
	datapath_model partner (.clk(clk), .rst_n(rst_n), .slow(slow),
		.ctrl(ctrl), .b_reg_value(b_reg_value), .bus_done(bus_done));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// B value as seen before each edge
	always @(posedge clk)
		b_prev <= b_reg_value;

	// Step snapshot at mid-cycle, where registered outputs are settled
	always @(negedge clk) begin
		if (ctrl.step_valid === 1'b1) begin
			got = 1'b1;
			s_ctrl = ctrl;
			s_b = b_leg_data;
			s_bp = b_prev;
			s_cnt = cnt;
			s_hold = hold;
			if (ring) begin
				check(cnt === ring_ex, "ring order");
				ring_ex = (ring_ex + 8'h1) & 8'h3;
				steps++;
			end
		end
	end

	task automatic stop_test;
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic timeout;
		check(1'b0, "wait ran out");
		stop_test();
	endtask : timeout

	// Write: address and data offered together, released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic aw, wr, b;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			aw = awvalid & awready;
			wr = wvalid & wready;
			b = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw) awvalid <= 1'b0;
			if (wr) wvalid <= 1'b0;
			if (b) break;
		end
		bready <= 1'b0;
		if (n == 50) timeout();
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ar, rd;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ar = arvalid & arready;
			rd = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ar) arvalid <= 1'b0;
			if (rd) break;
		end
		rready <= 1'b0;
		if (n == 50) timeout();
	endtask : axi_rd

	task automatic load_word(input logic [39:0] w);
		logic [1:0] r;
		axi_wr(REG_CS_LO, w[31:0], r);
		axi_wr(REG_CS_HI, {24'h0, w[39:32]}, r);
	endtask : load_word

	// Reference decode of one word
	function automatic ctrl_t exp_ctrl(input logic [39:0] w,
		input branch_cond_t c);
		ctrl_t e;
		logic [3:0] t;
		e = '0;
		t = w[11:8];
		e.step_valid = 1'b1;
		e.b_reg_control = w[24:23];
		e.a_leg_select = w[26:25];
		e.alu_fn = w[37:33];
		e.alu_aux = w[20];
		e.alu_carry_input = w[15];
		e.b_leg_select = {w[14], w[16]};
		case ({w[19], w[17]})
		2'h0: e.scratch_addr = {w[21], w[12], w[22], w[18]};
		2'h1: e.scratch_addr = {1'b0, c.ir[8:6]};
		2'h2: e.scratch_addr = {1'b0, c.ir[2:0]};
		default: e.scratch_addr = {1'b0, c.addr_low};
		endcase
		e.scratch_store = w[13];
		e.addr_reg_load = w[31];
		e.status_word_ctl = w[32];
		e.bus_cycle_kind = w[28:27];
		e.byte_access_allow = w[29];
		e.clock_hold_on_bus = w[30];
		e.literal_rom_select = (t == 4'hb);
		e.bus_reset_trigger = (t == 4'hc);
		e.slave_sync_assert = (t == 4'hd);
		e.stack_limit_check_en = (t == 4'he);
		e.instr_reg_capture = (t == 4'hf);
		return e;
	endfunction : exp_ctrl

	// Upper byte: bits a test may set; lower byte: bits that must be set
	function automatic logic [15:0] exp_next(input logic [39:0] w,
		input branch_cond_t c);
		logic [7:0] n;
		n = w[7:0];
		case (w[11:8])
		4'h1, 4'h9: return {8'h01, n};
		4'h2: return {8'h00, n | c.decode_target};
		4'h3, 4'h5, 4'h7: return {8'h03, n};
		4'h4: return {8'h00, n | {5'h00, c.ir[5:3]}};
		4'h6: return {8'h00, n | {7'h00, c.int_pending}};
		4'h8: return {8'h00, n | {5'h00, c.console_key}};
		4'ha: return {8'h00, n | {4'h0, c.service_code}};
		default: return {8'h00, n};
		endcase
	endfunction : exp_next

	initial begin
		logic [39:0] w;
		logic [63:0] rnd;
		logic [31:0] d;
		logic [15:0] en, exp_b;
		logic [1:0] r;
		branch_cond_t cv;
		int n;
		void'($urandom(32'h2724));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		// Idle state, unmapped and read-only places
		axi_rd(REG_STATUS, d, r);
		check(d === 32'h0 && r === RESP_OKAY, "status after reset");
		axi_rd(8'h14, d, r);
		check(d === 32'h0 && r === RESP_SLVERR, "unmapped read");
		axi_wr(8'h20, 32'hffffffff, r);
		check(r === RESP_SLVERR, "unmapped write");
		axi_wr(REG_STATUS, 32'hffffffff, r);
		check(r === RESP_OKAY, "status write");
		// Single steps through every test code with random fields
		for (int k = 0; k < 48; k++) begin
			rnd = {$urandom(), $urandom()};
			w = rnd[39:0];
			w[11:8] = 4'(k % 16);
			w[30] = w[30] & (w[28:27] != BUS_NONE);
			if (k == 0) w[37:33] = ALU_A_OR_B;
			slow <= rnd[63];
			rnd = {$urandom(), $urandom()};
			cv = branch_cond_t'(rnd[34:0]);
			cond <= cv;
			bus_init <= 1'b1;
			@(posedge clk);
			bus_init <= 1'b0;
			axi_wr(REG_CS_ADDR, 32'h0, r);
			load_word(w);
			got = 1'b0;
			axi_wr(REG_CTRL, 32'h2, r);
			for (n = 0; n < 20 && !got; n++) @(negedge clk);
			if (!got) timeout();
			check(s_ctrl === exp_ctrl(w, cv), "control fields");
			en = exp_next(w, cv);
			check((s_cnt | en[15:8]) === (en[7:0] | en[15:8]), "branch");
			check((s_cnt & en[7:0]) === en[7:0], "next address");
			exp_b = w[16] ? B_CONST_ONE
				: (w[14] ? {{8{s_bp[7]}}, s_bp[7:0]} : s_bp);
			check(s_b === exp_b, "b leg");
			check(s_hold === w[30], "bus wait entry");
			for (n = 0; n < 20 && hold !== 1'b0; n++) @(negedge clk);
			check(hold === 1'b0, "bus wait release");
			axi_rd(REG_STATUS, d, r);
			check(d[7:0] === s_cnt, "status counter");
			// Store read-back through the address register
			axi_wr(REG_CS_ADDR, 32'h0, r);
			axi_rd(REG_CS_LO, d, r);
			check(d === w[31:0], "store low word");
			axi_rd(REG_CS_HI, d, r);
			check(d === {24'h0, w[39:32]}, "store high byte");
		end
		// Free run round a four-word ring; word two waits on the bus
		bus_init <= 1'b1;
		@(posedge clk);
		bus_init <= 1'b0;
		axi_wr(REG_CS_ADDR, 32'h0, r);
		for (int i = 0; i < 4; i++)
			load_word({9'h0, 1'(i == 2), 1'b0, (i == 2) ? BUS_DATI : BUS_NONE,
				19'h0, 8'((i + 1) % 4)});
		slow <= 1'b1;
		ring_ex = 8'h1;
		ring = 1'b1;
		axi_wr(REG_CTRL, 32'h1, r);
		repeat (80) @(posedge clk);
		// Reset in mid-run must stop the sequencer
		rst_n <= 1'b0;
		ring = 1'b0;
		check(steps > 16, "run rate");
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		axi_rd(REG_CTRL, d, r);
		check(d === 32'h0, "run after reset");
		axi_rd(REG_STATUS, d, r);
		check(d === 32'h0, "status after mid-run reset");
		// Store survives reset: one step, then restart to the start
		axi_wr(REG_CTRL, 32'h2, r);
		axi_rd(REG_STATUS, d, r);
		check(d[7:0] === 8'h01, "step after reset");
		axi_wr(REG_CTRL, 32'h4, r);
		axi_rd(REG_STATUS, d, r);
		check(d === {24'h0, START_STEP}, "restart");
		stop_test();
	end
endmodule : tb_top
